// [hw/memory_map_decoder.sv]
// Memory-map decoder: selects the resource for each CPU access and holds the
// mapping and configuration registers.
// Assumes one clock (the bus clock), inputs synchronous to it, and a CPU
// that presents one access per cycle with i_acc_valid.
`timescale 1ns/1ns

// How it works
// - Registers beat RAM, RAM beats ROM
// - Normal mode: map written once, first 64 cycles
// - Special mode: protected registers writable any time
// - RAM page nibble sets RAM base, reset 0000
// - Register page nibble sets block base, reset 1000
// - ROM off goes external; single-chip forces on
// - EEPROM off goes external (none if single-chip), on means present
// - Security bit 1 disables; no option reads 1
// - Watchdog disable bit 1 stops watchdog
module memory_map_decoder #(
   parameter logic [15:0] RAM_SIZE        = 16'h0200,
   parameter logic [15:0] ROM_BASE        = 16'hd000,
   parameter logic [15:0] ROM_SIZE        = 16'h3000,
   parameter logic [15:0] EEPROM_BASE     = 16'hb600,
   parameter logic [15:0] EEPROM_SIZE     = 16'h0200,
   parameter logic        SECURITY_OPTION = 1'b0,
   parameter logic        SECURITY_RESET  = 1'b1,
   parameter logic        WATCHDOG_RESET  = 1'b0,
   parameter logic        EEPROM_RESET    = 1'b1
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_special_mode,
   input  wire logic        i_single_chip,
   input  wire logic        i_acc_valid,
   input  wire logic [15:0] i_acc_addr,
   input  wire logic [15:0] i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   output logic             o_sel_valid,
   output logic             o_sel_regs,
   output logic             o_sel_ram,
   output logic             o_sel_rom,
   output logic             o_sel_eeprom,
   output logic             o_sel_external,
   output logic             o_sel_none,
   output logic      [15:0] o_sel_offset,
   output logic             o_watchdog_run,
   output logic             o_security_on
);

   // True when addr lies in [base, base+size)
   function automatic logic in_range(input logic [15:0] addr,
                                     input logic [15:0] base,
                                     input logic [15:0] size);
      logic [16:0] top;
      top = {1'b0, base} + {1'b0, size};
      return ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
   endfunction

   // True when addr falls in the 64-byte block on the given page
   function automatic logic in_reg_block(input logic [15:0] addr,
                                         input logic [3:0]  page);
      return (addr[15:12] == page) && (addr[11:6] == 6'h00);
   endfunction

   logic [3:0]                   ram_page_q;
   logic [3:0]                   reg_page_q;
   logic                         security_disable_q;
   logic                         watchdog_disable_q;
   logic                         rom_enable_q;
   logic                         eeprom_enable_q;
   logic [6:0]                   cycle_cnt_q;
   logic                         map_written_q;
   logic                         cfg_written_q;
   memory_map_pkg::prot_state_t  prot_q;
   memory_map_pkg::target_t      target;
   logic [15:0]                  ram_base;
   logic [15:0]                  reg_base;
   logic                         port_regs;
   logic                         wr_map;
   logic                         wr_cfg;
   logic                         map_ok;
   logic                         cfg_ok;
   logic                         rom_live;
   logic                         security_read;
   logic [15:0]                  offset;

   assign ram_base  = {ram_page_q, 12'h000};
   assign reg_base  = {reg_page_q, 12'h000};
   assign port_regs = in_reg_block(i_reg_addr, reg_page_q);
   assign wr_map    = i_reg_wr && port_regs && (i_reg_addr[5:0] == memory_map_pkg::MAP_OFFSET);
   assign wr_cfg    = i_reg_wr && port_regs
                      && (i_reg_addr[5:0] == memory_map_pkg::CONFIG_OFFSET);
   // Special mode lifts the window; normal mode takes one write while open
   assign map_ok    = i_special_mode
                      || (prot_q == memory_map_pkg::PROT_OPEN && !map_written_q);
   assign cfg_ok    = i_special_mode
                      || (prot_q == memory_map_pkg::PROT_OPEN && !cfg_written_q);
   assign rom_live  = rom_enable_q || i_single_chip;
   // Without the manufacturing option the bit has no storage meaning
   assign security_read = SECURITY_OPTION ? security_disable_q : 1'b1;

   // Cycle counter for the early write window; saturates so it never wraps open
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cycle_cnt_q <= 7'h00;
      end else if (cycle_cnt_q != memory_map_pkg::WRITE_WINDOW_COUNT) begin
         cycle_cnt_q <= cycle_cnt_q + 7'h01;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prot_q <= memory_map_pkg::PROT_OPEN;
      end else begin
         case (prot_q)
            memory_map_pkg::PROT_OPEN: begin
               if (cycle_cnt_q == memory_map_pkg::WRITE_WINDOW_COUNT - 7'h01) begin
                  prot_q <= memory_map_pkg::PROT_LOCKED;
               end
            end
            memory_map_pkg::PROT_LOCKED: begin
               prot_q <= memory_map_pkg::PROT_LOCKED;
            end
            default: begin
               prot_q <= memory_map_pkg::PROT_LOCKED;
            end
         endcase
      end
   end

   // Mapping register
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ram_page_q    <= memory_map_pkg::RAM_PAGE_RESET;
         reg_page_q    <= memory_map_pkg::REG_PAGE_RESET;
         map_written_q <= 1'b0;
      end else if (wr_map && map_ok) begin
         ram_page_q    <= i_reg_wdata[memory_map_pkg::MAP_RAM_LSB +: 4];
         reg_page_q    <= i_reg_wdata[memory_map_pkg::MAP_REG_LSB +: 4];
         map_written_q <= !i_special_mode;
      end
   end

   // Configuration register, same write protection as the map
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         security_disable_q <= SECURITY_RESET;
         watchdog_disable_q <= WATCHDOG_RESET;
         rom_enable_q       <= memory_map_pkg::ROM_ENABLE_RESET;
         eeprom_enable_q    <= EEPROM_RESET;
         cfg_written_q      <= 1'b0;
      end else if (wr_cfg && cfg_ok) begin
         security_disable_q <= i_reg_wdata[memory_map_pkg::CFG_SECURITY_BIT];
         watchdog_disable_q <= i_reg_wdata[memory_map_pkg::CFG_WATCHDOG_BIT];
         rom_enable_q       <= i_reg_wdata[memory_map_pkg::CFG_ROM_BIT];
         eeprom_enable_q    <= i_reg_wdata[memory_map_pkg::CFG_EEPROM_BIT];
         cfg_written_q      <= !i_special_mode;
      end
   end

   // Read port: data stands in the cycle after the strobe only
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd && port_regs) begin
         case (i_reg_addr[5:0])
            memory_map_pkg::MAP_OFFSET: begin
               o_reg_rdata <= {ram_page_q, reg_page_q};
            end
            memory_map_pkg::CONFIG_OFFSET: begin
               o_reg_rdata <= {4'h0, security_read, watchdog_disable_q,
                               rom_enable_q, eeprom_enable_q};
            end
            default: begin
               o_reg_rdata <= 8'h00;
            end
         endcase
      end else begin
         o_reg_rdata <= 8'h00;
      end
   end

   // Priority decode on the live map values
   always_comb begin
      target = memory_map_pkg::SEL_NONE;
      offset = 16'h0000;
      if (in_reg_block(i_acc_addr, reg_page_q)) begin
         target = memory_map_pkg::SEL_REGS;
         offset = i_acc_addr - reg_base;
      end else if (in_range(i_acc_addr, ram_base, RAM_SIZE)) begin
         target = memory_map_pkg::SEL_RAM;
         offset = i_acc_addr - ram_base;
      end else if (rom_live && in_range(i_acc_addr, ROM_BASE, ROM_SIZE)) begin
         target = memory_map_pkg::SEL_ROM;
         offset = i_acc_addr - ROM_BASE;
      end else if (eeprom_enable_q && in_range(i_acc_addr, EEPROM_BASE, EEPROM_SIZE)) begin
         target = memory_map_pkg::SEL_EEPROM;
         offset = i_acc_addr - EEPROM_BASE;
      end else if (!i_single_chip) begin
         target = memory_map_pkg::SEL_EXTERNAL;
         offset = i_acc_addr;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sel_valid    <= 1'b0;
         o_sel_regs     <= 1'b0;
         o_sel_ram      <= 1'b0;
         o_sel_rom      <= 1'b0;
         o_sel_eeprom   <= 1'b0;
         o_sel_external <= 1'b0;
         o_sel_none     <= 1'b0;
         o_sel_offset   <= 16'h0000;
      end else begin
         o_sel_valid    <= i_acc_valid;
         o_sel_regs     <= i_acc_valid && (target == memory_map_pkg::SEL_REGS);
         o_sel_ram      <= i_acc_valid && (target == memory_map_pkg::SEL_RAM);
         o_sel_rom      <= i_acc_valid && (target == memory_map_pkg::SEL_ROM);
         o_sel_eeprom   <= i_acc_valid && (target == memory_map_pkg::SEL_EEPROM);
         o_sel_external <= i_acc_valid && (target == memory_map_pkg::SEL_EXTERNAL);
         o_sel_none     <= i_acc_valid && (target == memory_map_pkg::SEL_NONE);
         o_sel_offset   <= i_acc_valid ? offset : 16'h0000;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_watchdog_run <= 1'b0;
         o_security_on  <= 1'b0;
      end else begin
         o_watchdog_run <= !watchdog_disable_q;
         o_security_on  <= !security_read;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   property p_reg_over_ram;
      i_acc_valid && in_reg_block(i_acc_addr, reg_page_q)
      |=> o_sel_regs && !o_sel_ram && !o_sel_rom;
   endproperty
   a_reg_over_ram: assert property (p_reg_over_ram) else $error("register block lost priority");

   property p_ram_over_rom;
      i_acc_valid && !in_reg_block(i_acc_addr, reg_page_q)
      && in_range(i_acc_addr, ram_base, RAM_SIZE)
      |=> o_sel_ram && !o_sel_rom;
   endproperty
   a_ram_over_rom: assert property (p_ram_over_rom) else $error("RAM lost priority over ROM");

   property p_map_locked;
      !i_special_mode && (map_written_q || prot_q == memory_map_pkg::PROT_LOCKED)
      |=> $stable(ram_page_q) && $stable(reg_page_q);
   endproperty
   a_map_locked: assert property (p_map_locked) else $error("locked map register changed");

   property p_lock_at_64;
      cycle_cnt_q == memory_map_pkg::WRITE_WINDOW_COUNT |-> prot_q == memory_map_pkg::PROT_LOCKED;
   endproperty
   a_lock_at_64: assert property (p_lock_at_64) else $error("window open past 64 cycles");

   property p_special_write;
      i_special_mode && wr_map |=> {ram_page_q, reg_page_q} == $past(i_reg_wdata);
   endproperty
   a_special_write: assert property (p_special_write) else $error("special-mode write dropped");

   property p_ram_base;
      i_acc_valid && i_acc_addr == ram_base && reg_page_q != ram_page_q |=> o_sel_ram
      && o_sel_offset == 16'h0000;
   endproperty
   a_ram_base: assert property (p_ram_base) else $error("RAM not at its page start");

   property p_reg_last;
      i_acc_valid && i_acc_addr == (reg_base | 16'h003f) |=> o_sel_regs
      && o_sel_offset == 16'h003f;
   endproperty
   a_reg_last: assert property (p_reg_last) else $error("register block size wrong");

   property p_rom_off;
      i_acc_valid && !rom_enable_q && !i_single_chip && in_range(i_acc_addr, ROM_BASE, ROM_SIZE)
      && !in_reg_block(i_acc_addr, reg_page_q) && !in_range(i_acc_addr, ram_base, RAM_SIZE)
      && !in_range(i_acc_addr, EEPROM_BASE, EEPROM_SIZE) |=> o_sel_external;
   endproperty
   a_rom_off: assert property (p_rom_off) else $error("disabled ROM not external");

   property p_eeprom_off;
      i_acc_valid && !eeprom_enable_q |=> !o_sel_eeprom;
   endproperty
   a_eeprom_off: assert property (p_eeprom_off) else $error("disabled EEPROM selected");

   property p_security_read;
      i_reg_rd && i_reg_addr == memory_map_pkg::CONFIG_ADDR && reg_page_q == 4'h1 && !SECURITY_OPTION
      |=> o_reg_rdata[memory_map_pkg::CFG_SECURITY_BIT];
   endproperty
   a_security_read: assert property (p_security_read) else $error("security bit not 1");

   // Follows the written bit through the register, not the register itself
   property p_watchdog;
      wr_cfg && cfg_ok
      |=> ##1 o_watchdog_run == !$past(i_reg_wdata[memory_map_pkg::CFG_WATCHDOG_BIT], 2);
   endproperty
   a_watchdog: assert property (p_watchdog) else $error("watchdog run wrong");

   property p_single_chip;
      i_single_chip |=> !o_sel_external;
   endproperty
   a_single_chip: assert property (p_single_chip) else $error("external access in single-chip");

   property p_relocate;
      wr_map && map_ok ##1 i_acc_valid && in_reg_block(i_acc_addr, $past(i_reg_wdata[3:0]))
      |=> o_sel_regs;
   endproperty
   a_relocate: assert property (p_relocate) else $error("relocation not applied");

endmodule // memory_map_decoder

// [common/memory_map_pkg.sv]
// Constants and types shared by the memory-map decoder.
// Assumes a 16-bit CPU address space split into 4-Kbyte pages.
package memory_map_pkg;

   // Register block geometry
   localparam logic [15:0] REG_BLOCK_SIZE   = 16'h0040;
   localparam logic [5:0]  CONFIG_OFFSET    = 6'h3f;
   localparam logic [5:0]  MAP_OFFSET       = 6'h3d;
   localparam logic [15:0] CONFIG_ADDR      = 16'h103f;

   // Mapping register layout: RAM page in the upper nibble, register page in the lower
   localparam int          MAP_RAM_LSB      = 4;
   localparam int          MAP_REG_LSB      = 0;
   localparam logic [3:0]  RAM_PAGE_RESET   = 4'h0;
   localparam logic [3:0]  REG_PAGE_RESET   = 4'h1;

   // Configuration register layout
   localparam int          CFG_SECURITY_BIT = 3;
   localparam int          CFG_WATCHDOG_BIT = 2;
   localparam int          CFG_ROM_BIT      = 1;
   localparam int          CFG_EEPROM_BIT   = 0;
   localparam logic        ROM_ENABLE_RESET = 1'b1;

   // Early write window after reset, in clock cycles
   localparam int          WRITE_WINDOW_CYCLES = 64;
   localparam logic [6:0]  WRITE_WINDOW_COUNT  = 7'(WRITE_WINDOW_CYCLES);

   // Write protection phase of the write-once registers
   typedef enum logic {
      PROT_OPEN,
      PROT_LOCKED
   } prot_state_t;

   // Resource that answers one CPU access
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_REGS,
      SEL_RAM,
      SEL_ROM,
      SEL_EEPROM,
      SEL_EXTERNAL
   } target_t;

endpackage

// [verif/cpu_access_model.sv]
// CPU core model: issues one memory access for each call of access().
// Assumes the decoder samples the access on the rising edge after it is raised.
`timescale 1ns/1ns
module cpu_access_model (
   input  wire logic        i_ref_clk,
   output logic             o_acc_valid,
   output logic      [15:0] o_acc_addr
);
   initial begin
      o_acc_valid = 1'b0;
      o_acc_addr  = 16'h0000;
   end

   task automatic access(input logic [15:0] addr);
      @(posedge i_ref_clk);
      o_acc_valid <= 1'b1;
      o_acc_addr  <= addr;
      @(posedge i_ref_clk);
      o_acc_valid <= 1'b0;
      // Idle bus shows the inverse, so a stale address never passes for a live one
      o_acc_addr  <= ~addr;
   endtask
endmodule // cpu_access_model

// [verif/tb_memory_map_decoder.sv]
// Self-checking bench for the memory-map decoder with a CPU access model.
// Assumes default design parameters and a 125 MHz reference clock.
`timescale 1ns/1ns
module tb_memory_map_decoder;
   logic        clk;
   logic        rst_n;
   logic        special;
   logic        single;
   logic [15:0] reg_addr;
   logic [7:0]  wdata;
   logic        wr_s;
   logic        rd_s;
   logic        acc_valid;
   logic [15:0] acc_addr;
   logic [7:0]  o_reg_rdata;
   logic        o_sel_valid, o_sel_regs, o_sel_ram, o_sel_rom;
   logic        o_sel_eeprom, o_sel_external, o_sel_none;
   logic [15:0] o_sel_offset;
   logic        o_watchdog_run, o_security_on;
   logic [3:0]  ram_pg, reg_pg;
   logic        rom_e, ee_e;
   logic [31:0] r;
   int          seed;
   int          bad_count;
   int          checks_done;
   int          cycles;

   cpu_access_model cpu (.i_ref_clk(clk), .o_acc_valid(acc_valid), .o_acc_addr(acc_addr));

   memory_map_decoder dut (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_special_mode(special),
      .i_single_chip(single), .i_acc_valid(acc_valid), .i_acc_addr(acc_addr),
      .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
      .o_reg_rdata(o_reg_rdata), .o_sel_valid(o_sel_valid), .o_sel_regs(o_sel_regs),
      .o_sel_ram(o_sel_ram), .o_sel_rom(o_sel_rom), .o_sel_eeprom(o_sel_eeprom),
      .o_sel_external(o_sel_external), .o_sel_none(o_sel_none),
      .o_sel_offset(o_sel_offset), .o_watchdog_run(o_watchdog_run),
      .o_security_on(o_security_on));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Expected {regs,ram,rom,eeprom,external,none} and offset for an address
   function automatic logic [21:0] exp_sel(input logic [15:0] a);
      if (a[15:12] == reg_pg && a[11:6] == 6'h00) return {6'h20, 10'h000, a[5:0]};
      if (a[15:12] == ram_pg && a[11:0] < 12'h200) return {6'h10, 4'h0, a[11:0]};
      if ((rom_e || single) && a >= 16'hd000) return {6'h08, a - 16'hd000};
      if (ee_e && a >= 16'hb600 && a < 16'hb800) return {6'h04, a - 16'hb600};
      if (single) return {6'h01, 16'h0000};
      return {6'h02, a};
   endfunction

   task automatic close_out();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic acc(input logic [15:0] a);
      logic [21:0] e;
      cpu.access(a);
      e = exp_sel(a);
      #1;
      chk("target", {10'h000, e[21:16]}, {10'h000, o_sel_regs, o_sel_ram, o_sel_rom,
          o_sel_eeprom, o_sel_external, o_sel_none});
      chk("offset", e[15:0], o_sel_offset);
      chk("sel_valid", 16'h0001, {15'h0000, o_sel_valid});
   endtask

   task automatic wr(input logic [5:0] off, input logic [7:0] d);
      @(posedge clk);
      wr_s     <= 1'b1;
      reg_addr <= {reg_pg, 6'h00, off};
      wdata    <= d;
      @(posedge clk);
      wr_s     <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] off, input logic [7:0] exp);
      @(posedge clk);
      rd_s     <= 1'b1;
      reg_addr <= {reg_pg, 6'h00, off};
      @(posedge clk);
      rd_s     <= 1'b0;
      #1;
      chk("rdata", {8'h00, exp}, {8'h00, o_reg_rdata});
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n  <= 1'b1;
      ram_pg = 4'h0;
      reg_pg = 4'h1;
      rom_e  = 1'b1;
      ee_e   = 1'b1;
   endtask

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      rst_n = 1'b0;
      special = 1'b0;
      single = 1'b0;
      reg_addr = 16'h0000;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      seed = 53035;
      bad_count = 0;
      checks_done = 0;
      cycles = 0;
      do_reset();
      rd(6'h3f, 8'h0b);
      rd(6'h3d, 8'h01);
      rd(6'h3e, 8'h00);
      chk("watchdog_run", 16'h0001, {15'h0000, o_watchdog_run});
      chk("security_on", 16'h0000, {15'h0000, o_security_on});
      acc(16'h1005);
      acc(16'h0100);
      acc(16'he000);
      acc(16'hb610);
      // Access right behind the relocating write must already see the new page
      fork
         begin
            wr(6'h3d, 8'h32);
            ram_pg = 4'h3;
            reg_pg = 4'h2;
         end
         begin
            @(posedge clk);
            acc(16'h2005);
         end
      join
      acc(16'h1005);
      acc(16'h3010);
      acc(16'h3000);
      acc(16'h203f);
      wr(6'h3d, 8'h45);
      rd(6'h3d, 8'h32);
      wr(6'h3f, 8'h04);
      rom_e = 1'b0;
      ee_e = 1'b0;
      rd(6'h3f, 8'h0c);
      chk("watchdog_run", 16'h0000, {15'h0000, o_watchdog_run});
      acc(16'he000);
      acc(16'hb610);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         single <= i[0];
         repeat (30) begin
            r = $random(seed);
            if (r[17]) r[11:6] = 6'h00;
            acc(r[15:0]);
         end
      end
      acc(16'he000);
      do_reset();
      @(posedge clk);
      single <= 1'b0;
      wr(6'h3d, 8'h11);
      ram_pg = 4'h1;
      acc(16'h1005);
      acc(16'h1100);
      repeat (70) @(posedge clk);
      wr(6'h3d, 8'hd1);
      rd(6'h3d, 8'h11);
      @(posedge clk);
      special <= 1'b1;
      wr(6'h3d, 8'hd1);
      ram_pg = 4'hd;
      acc(16'hd010);
      wr(6'h3d, 8'he1);
      ram_pg = 4'he;
      rd(6'h3d, 8'he1);
      wr(6'h3f, 8'h06);
      rd(6'h3f, 8'h0e);
      // Window edges: the last open cycle takes the write, the next one refuses it
      do_reset();
      special <= 1'b0;
      repeat (62) @(posedge clk);
      wr(6'h3d, 8'h23);
      ram_pg = 4'h2;
      reg_pg = 4'h3;
      rd(6'h3d, 8'h23);
      do_reset();
      repeat (63) @(posedge clk);
      wr(6'h3d, 8'h23);
      rd(6'h3d, 8'h01);
      close_out();
   end
endmodule // tb_memory_map_decoder
